// ---- hw/can_bit_timing_dpll.sv ----
// bit timing and resynchronisation logic with an AXI4-Lite register slave
// Function
// - propagation segment programmable from one to eight quanta
// - phase one 1..8 quanta, phase two 2..8 quanta
// - each segment length is field value plus one quanta
// - sync segment is one quantum, starts every bit, edges expected there
// - single sample at end of phase one when triple sampling off
// - triple sampling adds two earlier samples, majority decides
// - processing time two quanta; nominal phase two never shorter
// - jump width is field value plus one quanta
// - quantum is two oscillator periods times prescale value plus one
// - mode bit picks phase two field, else max of phase one and two quanta
// - hard sync on falling edge while bus idle restarts bit counters
// - no resync in a bit that already had a hard sync
// - phase error zero in sync, positive before sample, negative after
// - error within jump width restarts bit like a hard sync
// - large positive error lengthens phase one by jump width
// - large negative error shortens phase two by jump width
// - only recessive to dominant edges are used
// - at most one synchronisation per bit time
// - edge used only if previous sampled bit was recessive
// - no resync on positive error while transmitting
// - timing registers writable only in configuration mode
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps
module can_bit_timing_dpll (
   input  logic                     aclk,
   input  logic                     aresetn,
   input  logic                     awvalid,
   output logic                     awready,
   input  logic [7:0]               awaddr,
   input  logic                     wvalid,
   output logic                     wready,
   input  logic [31:0]              wdata,
   input  logic [3:0]               wstrb,
   output logic                     bvalid,
   input  logic                     bready,
   output logic [1:0]               bresp,
   input  logic                     arvalid,
   output logic                     arready,
   input  logic [7:0]               araddr,
   output logic                     rvalid,
   input  logic                     rready,
   output logic [31:0]              rdata,
   output logic [1:0]               rresp,
   input  logic                     bus_receive_pin,
   input  logic                     bus_idle,
   input  logic                     tx_active,
   input  logic                     tx_level,
   output logic                     bus_transmit_pin,
   output logic                     rx_bit,
   output logic                     sample_pulse,
   output logic                     bit_start,
   output can_bit_timing_pkg::seg_e bit_segment
);
   import can_bit_timing_pkg::*;

   typedef struct packed {
      logic [7:0]  prescale_jump;
      logic [7:0]  segments;
      logic [7:0]  phase_two;
      logic        config_mode;
      logic        aw_got;
      logic [7:0]  aw_addr;
      logic        w_got;
      logic [7:0]  w_byte;
      logic        w_lane0;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        rx_meta;
      logic        rx_sync;
      logic        rx_prev;
      logic [6:0]  osc_cnt;
      seg_e        seg;
      logic [3:0]  tq_cnt;
      logic [2:0]  ps1_ext;
      logic [2:0]  ps2_short;
      logic        synced;
      logic        s0;
      logic        s1;
      logic        rx_bit;
      logic        tx_pin;
      logic        bit_start;
      logic        sample_pulse;
   } state_s;

   state_s st_r;
   state_s st_nxt;

   function automatic logic reg_known(input logic [7:0] a);
      reg_known = (a == ADDR_PRESCALE_JUMP) || (a == ADDR_SEGMENTS) ||
                  (a == ADDR_PHASE_TWO) || (a == ADDR_CONTROL) || (a == ADDR_STATUS);
   endfunction

   function automatic logic [3:0] max_ipt(input logic [3:0] x);
      max_ipt = (x < IPT_TQ) ? IPT_TQ : x;
   endfunction

   function automatic logic [3:0] len_of(input logic [2:0] f);
      len_of = {1'b0, f} + 4'h1;
   endfunction

   function automatic logic maj3(input logic a, input logic b, input logic c);
      maj3 = (a & b) | (a & c) | (b & c);
   endfunction

   logic [5:0] brp;
   logic [2:0] sjw;
   logic [3:0] prop_len;
   logic [3:0] ps1_nom;
   logic [3:0] ps2_nom;
   logic [3:0] ps1_len;
   logic [3:0] ps2_len;
   logic [2:0] ext_now;
   logic [2:0] short_now;
   logic       triple_sample_select;
   logic       run;
   logic       tq_tick;
   logic       half_tick;
   logic       edge_fall;
   logic       edge_ok;
   logic       pos_err;
   logic       neg_err;
   logic [4:0] err_mag;
   logic       small_err;
   logic       restart;
   logic       lengthen;
   logic       shorten;
   logic       in_last;
   logic       tx_drive_level;

   assign brp      = st_r.prescale_jump[BRP_LSB +: BRP_W];
   assign sjw      = {1'b0, st_r.prescale_jump[SJW_LSB +: SJW_W]} + 3'h1;
   assign prop_len = len_of(st_r.segments[PRSEG_LSB +: SEG_W]);
   assign ps1_nom  = len_of(st_r.segments[PHSEG1_LSB +: SEG_W]);
   assign triple_sample_select      = st_r.segments[SAM_BIT];
   assign ps2_nom  = st_r.segments[PHASE_TWO_SOURCE_SELECT_BIT] ?
                     max_ipt(len_of(st_r.phase_two[PHSEG2_LSB +: SEG_W])) :
                     max_ipt(ps1_nom);
   assign run      = !st_r.config_mode;
   // quantum is 2*(brp+1) oscillator cycles, so the last count is {brp,1}
   assign tq_tick   = run && (st_r.osc_cnt == {brp, 1'b1});
   assign half_tick = run && (st_r.osc_cnt == {1'b0, brp});
   assign edge_fall = st_r.rx_prev && !st_r.rx_sync;
   assign edge_ok   = run && edge_fall && st_r.rx_bit && !st_r.synced;
   assign pos_err   = (st_r.seg == SEG_PROP) || (st_r.seg == SEG_PHASE1);
   assign neg_err   = (st_r.seg == SEG_PHASE2);

   always_comb begin
      case (st_r.seg)
         SEG_PROP:   err_mag = {1'b0, st_r.tq_cnt} + 5'h01;
         SEG_PHASE1: err_mag = {1'b0, prop_len} + {1'b0, st_r.tq_cnt} + 5'h01;
         SEG_PHASE2: err_mag = {1'b0, ps2_nom} - {1'b0, st_r.tq_cnt};
         default:    err_mag = 5'h00;
      endcase
   end

   assign small_err = (err_mag <= {2'b00, sjw});
   assign restart  = (edge_ok && bus_idle) ||
                     (edge_ok && !bus_idle && ((st_r.seg == SEG_SYNC) ||
                      (pos_err && small_err && !tx_active) || (neg_err && small_err)));
   assign lengthen = edge_ok && !bus_idle && pos_err && !small_err && !tx_active;
   assign shorten  = edge_ok && !bus_idle && neg_err && !small_err;
   assign ext_now   = lengthen ? sjw : st_r.ps1_ext;
   assign short_now = shorten ? sjw : st_r.ps2_short;
   assign ps1_len   = ps1_nom + {1'b0, ext_now};
   assign ps2_len   = ps2_nom - {1'b0, short_now};
   assign in_last   = (st_r.seg == SEG_PHASE1) && (st_r.tq_cnt == ps1_len - 4'h1);
   assign tx_drive_level = tx_active ? tx_level : 1'b1;

   assign awready = !st_r.aw_got && !st_r.bvalid;
   assign wready  = !st_r.w_got && !st_r.bvalid;
   assign arready = !st_r.rvalid;
   assign bvalid  = st_r.bvalid;
   assign bresp   = st_r.bresp;
   assign rvalid  = st_r.rvalid;
   assign rdata   = st_r.rdata;
   assign rresp   = st_r.rresp;
   assign bus_transmit_pin = st_r.tx_pin;
   assign rx_bit       = st_r.rx_bit;
   assign sample_pulse = st_r.sample_pulse;
   assign bit_start    = st_r.bit_start;
   assign bit_segment  = st_r.seg;

   always_comb begin
      st_nxt = st_r;
      st_nxt.bit_start    = 1'b0;
      st_nxt.sample_pulse = 1'b0;
      st_nxt.rx_meta = bus_receive_pin;
      st_nxt.rx_sync = st_r.rx_meta;
      st_nxt.rx_prev = st_r.rx_sync;

      if (awvalid && awready) begin
         st_nxt.aw_got  = 1'b1;
         st_nxt.aw_addr = awaddr;
      end
      if (wvalid && wready) begin
         st_nxt.w_got   = 1'b1;
         st_nxt.w_byte  = wdata[7:0];
         st_nxt.w_lane0 = wstrb[0];
      end
      if (st_r.bvalid && bready) begin
         st_nxt.bvalid = 1'b0;
      end
      if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got  = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp  = reg_known(st_r.aw_addr) ? RESP_OKAY : RESP_SLVERR;
         if (st_r.w_lane0) begin
            // timing words are frozen outside configuration mode
            if (st_r.config_mode && st_r.aw_addr == ADDR_PRESCALE_JUMP) begin
               st_nxt.prescale_jump = st_r.w_byte;
            end
            if (st_r.config_mode && st_r.aw_addr == ADDR_SEGMENTS) begin
               st_nxt.segments = st_r.w_byte;
            end
            if (st_r.config_mode && st_r.aw_addr == ADDR_PHASE_TWO) begin
               st_nxt.phase_two = st_r.w_byte & PHASE_TWO_MASK;
            end
            if (st_r.aw_addr == ADDR_CONTROL) begin
               st_nxt.config_mode = st_r.w_byte[CFG_BIT];
            end
         end
      end

      if (st_r.rvalid && rready) begin
         st_nxt.rvalid = 1'b0;
      end
      if (arvalid && arready) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp  = reg_known(araddr) ? RESP_OKAY : RESP_SLVERR;
         case (araddr)
            ADDR_PRESCALE_JUMP: st_nxt.rdata = {24'h00_0000, st_r.prescale_jump};
            ADDR_SEGMENTS:      st_nxt.rdata = {24'h00_0000, st_r.segments};
            ADDR_PHASE_TWO:     st_nxt.rdata = {24'h00_0000, st_r.phase_two};
            ADDR_CONTROL:       st_nxt.rdata = {31'h0000_0000, st_r.config_mode};
            ADDR_STATUS:        st_nxt.rdata = {27'h000_0000, st_r.tx_pin, st_r.seg,
                                                st_r.synced, st_r.rx_bit};
            default:            st_nxt.rdata = 32'h0000_0000;
         endcase
      end

      if (!run) begin
         // held at the start of a bit while configuring
         st_nxt.osc_cnt   = 7'h00;
         st_nxt.seg       = SEG_SYNC;
         st_nxt.tq_cnt    = 4'h0;
         st_nxt.ps1_ext   = 3'h0;
         st_nxt.ps2_short = 3'h0;
         st_nxt.synced    = 1'b0;
         st_nxt.rx_bit    = 1'b1;
         st_nxt.tx_pin    = 1'b1;
      end else if (restart) begin
         // edge becomes the sync quantum of a fresh bit
         st_nxt.osc_cnt   = 7'h00;
         st_nxt.seg       = SEG_SYNC;
         st_nxt.tq_cnt    = 4'h0;
         st_nxt.ps1_ext   = 3'h0;
         st_nxt.ps2_short = 3'h0;
         st_nxt.synced    = 1'b1;
         st_nxt.bit_start = 1'b1;
         st_nxt.tx_pin    = tx_drive_level;
      end else begin
         st_nxt.osc_cnt = tq_tick ? 7'h00 : st_r.osc_cnt + 7'h01;
         if (lengthen) begin
            st_nxt.ps1_ext = sjw;
            st_nxt.synced  = 1'b1;
         end
         if (shorten) begin
            st_nxt.ps2_short = sjw;
            st_nxt.synced    = 1'b1;
         end
         // early samples one quantum and half a quantum before the sample point
         if (in_last && st_r.osc_cnt == 7'h00) begin
            st_nxt.s0 = st_r.rx_prev;
         end
         if (in_last && half_tick) begin
            st_nxt.s1 = st_r.rx_sync;
         end
         if (tq_tick) begin
            case (st_r.seg)
               SEG_SYNC: begin
                  st_nxt.seg    = SEG_PROP;
                  st_nxt.tq_cnt = 4'h0;
               end
               SEG_PROP: begin
                  if (st_r.tq_cnt == prop_len - 4'h1) begin
                     st_nxt.seg    = SEG_PHASE1;
                     st_nxt.tq_cnt = 4'h0;
                  end else begin
                     st_nxt.tq_cnt = st_r.tq_cnt + 4'h1;
                  end
               end
               SEG_PHASE1: begin
                  if (in_last) begin
                     st_nxt.rx_bit = triple_sample_select ? maj3(st_r.s0, st_r.s1, st_r.rx_sync) :
                                           st_r.rx_sync;
                     st_nxt.sample_pulse = 1'b1;
                     st_nxt.seg    = SEG_PHASE2;
                     st_nxt.tq_cnt = 4'h0;
                  end else begin
                     st_nxt.tq_cnt = st_r.tq_cnt + 4'h1;
                  end
               end
               SEG_PHASE2: begin
                  if (st_r.tq_cnt + 4'h1 >= ps2_len) begin
                     st_nxt.seg       = SEG_SYNC;
                     st_nxt.tq_cnt    = 4'h0;
                     st_nxt.ps1_ext   = 3'h0;
                     st_nxt.ps2_short = 3'h0;
                     st_nxt.synced    = 1'b0;
                     st_nxt.bit_start = 1'b1;
                     st_nxt.tx_pin    = tx_drive_level;
                  end else begin
                     st_nxt.tq_cnt = st_r.tq_cnt + 4'h1;
                  end
               end
               default: st_nxt.seg = SEG_SYNC;
            endcase
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r               <= '0;
         st_r.prescale_jump <= RST_PRESCALE_JUMP;
         st_r.segments      <= RST_SEGMENTS;
         st_r.phase_two     <= RST_PHASE_TWO;
         st_r.config_mode   <= RST_CONFIG_MODE;
         st_r.rx_meta       <= 1'b1;
         st_r.rx_sync       <= 1'b1;
         st_r.rx_prev       <= 1'b1;
         st_r.rx_bit        <= 1'b1;
         st_r.tx_pin        <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   property p_cfg_lock;
      @(posedge aclk) disable iff (!aresetn)
      (!st_r.config_mode && st_r.aw_got && st_r.w_got && !st_r.bvalid) |=>
         $stable(st_r.prescale_jump) && $stable(st_r.segments) && $stable(st_r.phase_two);
   endproperty
   a_cfg_lock: assert property (p_cfg_lock) else $error("timing word changed");

   property p_sync_one;
      @(posedge aclk) disable iff (!aresetn)
      (st_r.seg == SEG_SYNC && tq_tick && !restart) |=> st_r.seg == SEG_PROP;
   endproperty
   a_sync_one: assert property (p_sync_one) else $error("sync not one quantum");

   property p_prop_len;
      @(posedge aclk) disable iff (!aresetn)
      (st_r.seg == SEG_PROP && tq_tick && !restart && st_r.tq_cnt == prop_len - 4'h1)
         |=> st_r.seg == SEG_PHASE1 && st_r.tq_cnt == 4'h0;
   endproperty
   a_prop_len: assert property (p_prop_len) else $error("prop length wrong");

   property p_ps1_len;
      @(posedge aclk) disable iff (!aresetn)
      (st_r.seg == SEG_PHASE1 && tq_tick && !restart && !in_last) |=>
         st_r.seg == SEG_PHASE1 && !st_r.sample_pulse;
   endproperty
   a_ps1_len: assert property (p_ps1_len) else $error("phase one ended early");

   property p_ps2_floor;
      @(posedge aclk) disable iff (!aresetn)
      run |-> ps2_nom >= IPT_TQ && ps2_nom <= 4'h8;
   endproperty
   a_ps2_floor: assert property (p_ps2_floor) else $error("phase two out of range");

   property p_ps2_src;
      @(posedge aclk) disable iff (!aresetn)
      !st_r.segments[PHASE_TWO_SOURCE_SELECT_BIT] |-> ps2_nom == max_ipt(ps1_nom);
   endproperty
   a_ps2_src: assert property (p_ps2_src) else $error("phase two source wrong");

   property p_single;
      @(posedge aclk) disable iff (!aresetn)
      (st_r.sample_pulse && !triple_sample_select) |-> st_r.rx_bit == $past(st_r.rx_sync);
   endproperty
   a_single: assert property (p_single) else $error("single sample wrong");

   property p_triple;
      @(posedge aclk) disable iff (!aresetn)
      (st_r.sample_pulse && triple_sample_select) |->
         st_r.rx_bit == maj3($past(st_r.s0), $past(st_r.s1), $past(st_r.rx_sync));
   endproperty
   a_triple: assert property (p_triple) else $error("majority wrong");

   property p_lengthen;
      @(posedge aclk) disable iff (!aresetn)
      lengthen |=> st_r.ps1_ext == $past(sjw) && st_r.synced;
   endproperty
   a_lengthen: assert property (p_lengthen) else $error("phase one not lengthened");

   property p_shorten;
      @(posedge aclk) disable iff (!aresetn)
      // an edge on the closing tick of the last shortened quantum ends the bit at once
      shorten |=> st_r.bit_start || (st_r.ps2_short == $past(sjw) && st_r.synced);
   endproperty
   a_shorten: assert property (p_shorten) else $error("phase two not shortened");

   property p_rise;
      @(posedge aclk) disable iff (!aresetn)
      (!st_r.rx_prev && st_r.rx_sync) |-> !restart && !lengthen && !shorten;
   endproperty
   a_rise: assert property (p_rise) else $error("rising edge used");

   property p_once;
      @(posedge aclk) disable iff (!aresetn)
      st_r.synced |-> !restart && !lengthen && !shorten;
   endproperty
   a_once: assert property (p_once) else $error("second sync in bit");

   property p_prev_rec;
      @(posedge aclk) disable iff (!aresetn)
      (restart || lengthen || shorten) |-> st_r.rx_bit;
   endproperty
   a_prev_rec: assert property (p_prev_rec) else $error("sync after dominant");

   property p_no_pos_tx;
      @(posedge aclk) disable iff (!aresetn)
      (tx_active && pos_err && !bus_idle) |-> !lengthen && !restart;
   endproperty
   a_no_pos_tx: assert property (p_no_pos_tx) else $error("resync while sending");

   property p_hard;
      @(posedge aclk) disable iff (!aresetn)
      (edge_ok && bus_idle) |=> st_r.seg == SEG_SYNC && st_r.osc_cnt == 7'h00 ##1
         st_r.osc_cnt == 7'h01 || st_r.seg != SEG_SYNC || !run;
   endproperty
   a_hard: assert property (p_hard) else $error("hard sync did not restart");

   property p_tx_drive;
      @(posedge aclk) disable iff (!aresetn)
      st_r.bit_start |-> st_r.tx_pin == $past(tx_drive_level);
   endproperty
   a_tx_drive: assert property (p_tx_drive) else $error("tx level wrong");

   property p_tq_min;
      @(posedge aclk) disable iff (!aresetn)
      tq_tick |=> !tq_tick;
   endproperty
   a_tq_min: assert property (p_tq_min) else $error("quantum too short");

   c_hard: cover property (@(posedge aclk) disable iff (!aresetn) edge_ok && bus_idle);
   c_lengthen: cover property (@(posedge aclk) disable iff (!aresetn) lengthen);
   c_shorten: cover property (@(posedge aclk) disable iff (!aresetn) shorten);
   c_triple: cover property (@(posedge aclk) disable iff (!aresetn) st_r.sample_pulse && triple_sample_select);
endmodule

// ---- hw/can_bit_timing_pkg.sv ----
// constants and types shared by the bit timing block
package can_bit_timing_pkg;
   localparam logic [7:0] ADDR_PRESCALE_JUMP = 8'h00;
   localparam logic [7:0] ADDR_SEGMENTS      = 8'h04;
   localparam logic [7:0] ADDR_PHASE_TWO     = 8'h08;
   localparam logic [7:0] ADDR_CONTROL       = 8'h0C;
   localparam logic [7:0] ADDR_STATUS        = 8'h10;

   localparam int BRP_LSB     = 0;
   localparam int BRP_W       = 6;
   localparam int SJW_LSB     = 6;
   localparam int SJW_W       = 2;
   localparam int PRSEG_LSB   = 0;
   localparam int PHSEG1_LSB  = 3;
   localparam int PHSEG2_LSB  = 0;
   localparam int SEG_W       = 3;
   localparam int SAM_BIT     = 6;
   localparam int PHASE_TWO_SOURCE_SELECT_BIT = 7;
   localparam int CFG_BIT     = 0;

   localparam logic [7:0] RST_PRESCALE_JUMP = 8'h00;
   localparam logic [7:0] RST_SEGMENTS      = 8'h00;
   localparam logic [7:0] RST_PHASE_TWO     = 8'h00;
   localparam logic [7:0] PHASE_TWO_MASK    = 8'h07;
   localparam logic       RST_CONFIG_MODE   = 1'b1;

   // fixed information processing time, in quanta
   localparam logic [3:0] IPT_TQ = 4'h2;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      SEG_SYNC   = 2'b00,
      SEG_PROP   = 2'b01,
      SEG_PHASE1 = 2'b10,
      SEG_PHASE2 = 2'b11
   } seg_e;
endpackage

// ---- testbench/can_bit_timing_dpll_tb.sv ----
// self-checking bench for the bit timing block
`timescale 1ns/100ps
module can_bit_timing_dpll_tb;
   import can_bit_timing_pkg::*;
   logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic        arvalid = 0, rready = 0, bus_idle = 0, tx_active = 0, tx_level = 1;
   logic        send_dom = 0, awready, wready, bvalid, arready, rvalid;
   logic        rx_bit, sample_pulse, bit_start, bus_transmit_pin, bus_receive_pin;
   logic [7:0]  awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, rd;
   logic [3:0]  wstrb = 4'h1;
   logic [1:0]  bresp, rresp, rs;
   seg_e        bit_segment;
   int          fails = 0, cmp_count = 0, cyc = 0, ts, d, e, el;
   // software keeps prop+ps1 >= ps2 and ps2 >= jump width in every row
   logic [7:0]  pj_t [6] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h41, 8'h00};
   logic [7:0]  sg_t [6] = '{8'h00, 8'h00, 8'hB9, 8'h38, 8'h07, 8'hC0};
   logic [7:0]  p2_t [6] = '{8'hFF, 8'h00, 8'h07, 8'h05, 8'h00, 8'h01};

   can_bit_timing_dpll u_dut (
      .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
      .rdata(rdata), .rresp(rresp), .bus_receive_pin(bus_receive_pin),
      .bus_idle(bus_idle), .tx_active(tx_active), .tx_level(tx_level),
      .bus_transmit_pin(bus_transmit_pin), .rx_bit(rx_bit),
      .sample_pulse(sample_pulse), .bit_start(bit_start), .bit_segment(bit_segment)
   );
   can_bus_node_model u_node (
      .aclk(aclk), .own_tx(bus_transmit_pin), .send_dom(send_dom),
      .bus_line(bus_receive_pin)
   );

   always #2.5 aclk = ~aclk;

   task automatic finish_test();
      if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // run takes under a thousand cycles; this only cuts a hang short
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         finish_test();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] dv, input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      wdata <= dv;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end while ((awvalid && !awready) || (wvalid && !wready));
      while (!bvalid) @(posedge aclk);
      bready <= 0;
      check(32'(bresp), 32'(er));
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do @(posedge aclk); while (!arready);
      arvalid <= 0;
      do @(posedge aclk); while (!rvalid);
      dv = rdata;
      r = rresp;
      rready <= 0;
   endtask

   // cycles up to the next bit start, and where the sample fell
   task automatic to_start(output int so, output int n);
      so = 0;
      n = 0;
      do begin
         @(posedge aclk);
         #1;
         n++;
         if (sample_pulse) so = n;
      end while (!bit_start && n < 500);
   endtask

   function automatic int blen(input logic [7:0] pj, input logic [7:0] sg,
                               input logic [7:0] p2, output int so);
      int q, pr, p1, ps2;
      q = 2 * (pj[5:0] + 1);
      pr = sg[2:0] + 1;
      p1 = sg[5:3] + 1;
      ps2 = sg[7] ? p2[2:0] + 1 : (p1 > 2 ? p1 : 2);
      if (ps2 < 2) ps2 = 2;
      so = (1 + pr + p1) * q;
      return (1 + pr + p1 + ps2) * q;
   endfunction

   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1;
      for (int i = 0; i < 5; i++) begin
         axi_rd(8'(4 * i), rd, rs);
         check(rd, (i == 4) ? 32'h0000_0011 : 32'(i == 3));
         check(32'(rs), 32'(RESP_OKAY));
      end
      axi_rd(8'h14, rd, rs);
      check(32'(rs), 32'(RESP_SLVERR));
      check(rd, 32'h0000_0000);
      axi_wr(8'h14, 32'h0000_0001, RESP_SLVERR);
      for (int i = 0; i < 6; i++) begin
         axi_wr(ADDR_CONTROL, 32'h0000_0001, RESP_OKAY);
         axi_wr(ADDR_PRESCALE_JUMP, {24'h0, pj_t[i]}, RESP_OKAY);
         axi_wr(ADDR_SEGMENTS, {24'h0, sg_t[i]}, RESP_OKAY);
         axi_wr(ADDR_PHASE_TWO, {24'h0, p2_t[i]}, RESP_OKAY);
         axi_rd(ADDR_PRESCALE_JUMP, rd, rs);
         check(rd, {24'h0, pj_t[i]});
         axi_rd(ADDR_PHASE_TWO, rd, rs);
         check(rd, {24'h0, p2_t[i] & PHASE_TWO_MASK});
         axi_wr(ADDR_CONTROL, 32'h0000_0000, RESP_OKAY);
         axi_wr(ADDR_SEGMENTS, 32'h0000_0055, RESP_OKAY);
         axi_rd(ADDR_SEGMENTS, rd, rs);
         check(rd, {24'h0, sg_t[i]});
         to_start(ts, d);
         to_start(ts, d);
         el = blen(pj_t[i], sg_t[i], p2_t[i], e);
         check(32'(d), 32'(el));
         check(32'(ts), 32'(e));
         check(32'(bit_segment), 32'(SEG_SYNC));
      end
      // last row: ten cycles a bit
      @(posedge aclk);
      bus_idle <= 1;
      to_start(ts, d);
      @(posedge aclk);
      send_dom <= 1;
      to_start(ts, d);
      check(32'(d < 8), 32'h0000_0001);
      @(posedge aclk);
      bus_idle <= 0;
      to_start(ts, d);
      to_start(ts, d);
      check(32'(rx_bit), 32'h0000_0000);
      send_dom <= 0;
      to_start(ts, d);
      check(32'(d), 32'h0000_000A);
      // short dominant pulse: falls after the sample, rises early in the next bit
      repeat (3) @(posedge aclk);
      send_dom <= 1;
      repeat (3) @(posedge aclk);
      send_dom <= 0;
      to_start(ts, d);
      check(32'(d), 32'h0000_0002);
      to_start(ts, d);
      check(32'(d), 32'h0000_000A);
      @(posedge aclk);
      tx_active <= 1;
      tx_level <= 0;
      to_start(ts, d);
      check(32'(bus_transmit_pin), 32'h0000_0000);
      @(posedge aclk);
      tx_level <= 1;
      to_start(ts, d);
      check(32'(d), 32'h0000_0009);
      check(32'(bus_transmit_pin), 32'h0000_0001);
      finish_test();
   end
endmodule

// ---- testbench/can_bus_node_model.sv ----
// far-side node on the bus line, wired-and with the local transmitter
`timescale 1ns/100ps
module can_bus_node_model (
   input  wire logic aclk,
   input  wire logic own_tx,
   input  wire logic send_dom,
   output logic      bus_line
);
   logic drive_r;

   // the other node switches its driver just after an edge, like a real transceiver
   always_ff @(posedge aclk) begin
      drive_r <= send_dom;
   end

   // dominant wins: either driver pulls the line low
   assign bus_line = own_tx & ~drive_r;
endmodule
